// ---- design/bmsd_group.sv ----
// one strap group: pin synchroniser, mode latch and boot chip select
`timescale 1ns/1ps
module bmsd_group (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// strap pins of the group
	input wire bmsd_pkg::bmsd_strap_t strap_in,
	// bus ownership, same clock domain
	input wire logic drive_ok_in,
	input wire logic cs_req_n_in,
	// results
	output bmsd_pkg::bmsd_boot_t boot_out,
	output logic cs_n_out,
	output logic oe_n_out
);
	typedef struct packed {
		bmsd_pkg::bmsd_strap_t s1;
		bmsd_pkg::bmsd_strap_t s2;
		bmsd_pkg::bmsd_strap_t s3;
		logic [1:0] cnt;
		logic [1:0] fill;
		bmsd_pkg::bmsd_boot_t boot;
		logic cs_n;
		logic oe_n;
	} bmsd_grp_t;

	localparam bmsd_grp_t GRP_RST = '{
		s1: '0, s2: '0, s3: '0, cnt: 2'h0, fill: 2'h0,
		boot: '{mode: bmsd_pkg::BMSD_MODE_RST, valid: 1'h0},
		cs_n: bmsd_pkg::BMSD_CS_N_RST, oe_n: bmsd_pkg::BMSD_OE_N_RST};

	bmsd_grp_t q, d;
	logic drive;

	// sample once after release, then hold until the next reset
	always_comb begin
		d = q;
		d.s1 = strap_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// reset values in the chain must not pass for a settled strap
		if (q.fill != bmsd_pkg::BMSD_SYNC_FILL) begin
			d.fill = 2'(q.fill + 2'h1);
		end
		if (!q.boot.valid && (q.fill == bmsd_pkg::BMSD_SYNC_FILL)) begin
			if (q.s2 == q.s3) begin
				if (q.cnt == bmsd_pkg::BMSD_SETTLE_CYC) begin
					d.boot.mode = bmsd_pkg::bmsd_decode(q.s3);
					d.boot.valid = 1'h1;
				end else begin
					d.cnt = 2'(q.cnt + 2'h1);
				end
			end else begin
				d.cnt = 2'h0; // a glitch restarts the settle wait
			end
		end
		drive = q.boot.valid && (q.boot.mode == bmsd_pkg::BMSD_EPROM) &&
			drive_ok_in;
		d.oe_n = !drive;
		d.cs_n = drive ? cs_req_n_in : 1'h1;
	end

	// state register, synchronous reset
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			q <= GRP_RST;
		end else begin
			q <= d;
		end
	end

	assign boot_out = q.boot;
	assign cs_n_out = q.cs_n;
	assign oe_n_out = q.oe_n;

	// a latched mode never changes before reset
	a_grp_mode_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$past(q.boot.valid) |-> $stable(q.boot.mode))
		else $error("group boot mode changed after latch");
endmodule

// ---- design/bmsd_pkg.sv ----
// shared types, constants and decode for the boot-mode strap decoder
package bmsd_pkg;
	// one-hot boot modes
	typedef enum logic [4:0] {
		BMSD_NO_BOOT = 5'h01,
		BMSD_HOST = 5'h02,
		BMSD_LINK = 5'h04,
		BMSD_EPROM = 5'h08,
		BMSD_RSVD = 5'h10
	} bmsd_mode_t;

	// one strap group as seen on its pins
	typedef struct packed {
		logic eprom;
		logic link;
		logic sel;
	} bmsd_strap_t;

	// decoded boot mode with its valid flag
	typedef struct packed {
		bmsd_mode_t mode;
		logic valid;
	} bmsd_boot_t;

	// cycles the synchronised straps must stay steady before latching
	localparam logic [1:0] BMSD_SETTLE_CYC = 2'h3;
	// edges before the last synchroniser stage holds a real pin sample
	localparam logic [1:0] BMSD_SYNC_FILL = 2'h3;
	localparam bmsd_mode_t BMSD_MODE_RST = BMSD_NO_BOOT;
	localparam logic BMSD_CS_N_RST = 1'h1;
	localparam logic BMSD_OE_N_RST = 1'h1;
	localparam int BMSD_NUM_PROC = 4;
	localparam int BMSD_PROC_A = 0;

	// strap group to boot mode
	function automatic bmsd_mode_t bmsd_decode(input bmsd_strap_t s);
		bmsd_mode_t m;
		m = BMSD_RSVD;
		if (s.eprom) begin
			m = s.link ? BMSD_RSVD : BMSD_EPROM;
		end else if (s.sel) begin
			m = s.link ? BMSD_LINK : BMSD_HOST;
		end else begin
			m = s.link ? BMSD_RSVD : BMSD_NO_BOOT;
		end
		return m;
	endfunction
endpackage

// ---- design/bmsd_top.sv ----
// boot-mode strap decoder for a four-processor module
// Overview of operation
// - eprom strap high, link strap low: group boots from a byte-wide eprom
// - eprom low: link strap and select pin pick host, link, none, reserved
// - eprom high, link low: select pin drives the eprom chip select
// - select pin and link strap low outside eprom mode: no boot, run from external memory
// - select pin is driven only in eprom mode, otherwise it is an input
// - only the current bus master drives the boot chip select
// - chip select floats while bus suspend is asserted or as bus slave
// - processor a uses its own straps, b c d share one group
`timescale 1ns/1ps
module bmsd_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// strap pins, processor a
	input wire logic eprom_boot_strap_a_in,
	input wire logic link_boot_strap_a_in,
	input wire logic boot_select_a_in,
	// strap pins, processors b c d
	input wire logic eprom_boot_strap_bcd_in,
	input wire logic link_boot_strap_bcd_in,
	input wire logic boot_select_bcd_in,
	// bus state, pin and per processor core signals (index 0 is a)
	input wire logic bus_suspend_n_in,
	input wire logic [3:0] bus_master_in,
	input wire logic [3:0] eprom_cs_req_n_in,
	// boot select pin drivers, enable low while driving
	output logic boot_select_a_out,
	output logic boot_select_a_oe_n_out,
	output logic boot_select_bcd_out,
	output logic boot_select_bcd_oe_n_out,
	// decoded mode per processor and run-from-memory flags
	output bmsd_pkg::bmsd_boot_t [3:0] boot_mode_out,
	output logic [3:0] ext_exec_out
);
	typedef struct packed {
		logic sus1;
		logic sus2;
		logic sus3;
		logic suspended;
		bmsd_pkg::bmsd_boot_t [3:0] mode;
		logic [3:0] ext_exec;
	} bmsd_top_st_t;

	localparam bmsd_top_st_t TOP_RST = '{
		sus1: 1'h1, sus2: 1'h1, sus3: 1'h1, suspended: 1'h0,
		mode: {4{bmsd_pkg::bmsd_boot_t'{mode: bmsd_pkg::BMSD_MODE_RST,
			valid: 1'h0}}},
		ext_exec: 4'h0};

	bmsd_top_st_t q, d;
	bmsd_pkg::bmsd_boot_t boot_a, boot_bcd;
	bmsd_pkg::bmsd_strap_t strap_a, strap_bcd;
	logic ok_a, ok_bcd, req_bcd_n;

	// group pins gathered for the decoders
	assign strap_a = '{eprom: eprom_boot_strap_a_in,
		link: link_boot_strap_a_in, sel: boot_select_a_in};
	assign strap_bcd = '{eprom: eprom_boot_strap_bcd_in,
		link: link_boot_strap_bcd_in, sel: boot_select_bcd_in};

	// drive only as master and not suspended
	assign ok_a = bus_master_in[0] && !q.suspended;
	assign ok_bcd = (|bus_master_in[3:1]) && !q.suspended;
	// the shared pin takes the request of whichever of b c d is master
	assign req_bcd_n = &(eprom_cs_req_n_in[3:1] | ~bus_master_in[3:1]);

	// processor a on its own straps
	bmsd_group u_grp_a (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.strap_in(strap_a),
		.drive_ok_in(ok_a),
		.cs_req_n_in(eprom_cs_req_n_in[0]),
		.boot_out(boot_a),
		.cs_n_out(boot_select_a_out),
		.oe_n_out(boot_select_a_oe_n_out)
	);

	// b c d on one shared group
	bmsd_group u_grp_bcd (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.strap_in(strap_bcd),
		.drive_ok_in(ok_bcd),
		.cs_req_n_in(req_bcd_n),
		.boot_out(boot_bcd),
		.cs_n_out(boot_select_bcd_out),
		.oe_n_out(boot_select_bcd_oe_n_out)
	);

	// suspend pin sync and per processor fan-out of the modes
	always_comb begin
		d = q;
		d.sus1 = bus_suspend_n_in;
		d.sus2 = q.sus1;
		d.sus3 = q.sus2;
		// filtered level only moves when the last two stages agree
		if (q.sus2 == q.sus3) begin
			d.suspended = !q.sus3;
		end
		d.mode[bmsd_pkg::BMSD_PROC_A] = boot_a;
		for (int i = 1; i < bmsd_pkg::BMSD_NUM_PROC; i++) begin
			d.mode[i] = boot_bcd;
		end
		// no boot means execute from external memory
		for (int i = 0; i < bmsd_pkg::BMSD_NUM_PROC; i++) begin
			d.ext_exec[i] = d.mode[i].valid &&
				(d.mode[i].mode == bmsd_pkg::BMSD_NO_BOOT);
		end
	end

	// state register; reset assumed held at power-up by the system
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	assign boot_mode_out = q.mode;
	assign ext_exec_out = q.ext_exec;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	// straps seen alike five and six cycles before a fresh latch of group a
	a_eprom_decode: assert property ($rose(boot_a.valid) &&
		$past(eprom_boot_strap_a_in, 5) && $past(eprom_boot_strap_a_in, 6) &&
		!$past(link_boot_strap_a_in, 5) && !$past(link_boot_strap_a_in, 6)
		|-> boot_a.mode == bmsd_pkg::BMSD_EPROM)
		else $error("eprom strap did not give eprom mode");

	a_host_decode: assert property ($rose(boot_a.valid) &&
		!$past(eprom_boot_strap_a_in, 5) && !$past(eprom_boot_strap_a_in, 6) &&
		!$past(link_boot_strap_a_in, 5) && !$past(link_boot_strap_a_in, 6) &&
		$past(boot_select_a_in, 5) && $past(boot_select_a_in, 6)
		|-> boot_a.mode == bmsd_pkg::BMSD_HOST)
		else $error("host straps did not give host mode");

	a_drive_eprom: assert property (!boot_select_a_oe_n_out
		|-> $past(boot_a.mode) == bmsd_pkg::BMSD_EPROM && $past(boot_a.valid))
		else $error("select pin driven outside eprom mode");

	a_ext_exec: assert property (ext_exec_out[0]
		|-> boot_mode_out[0].mode == bmsd_pkg::BMSD_NO_BOOT)
		else $error("external execution flag without no-boot mode");

	a_input_only: assert property (boot_bcd.valid &&
		boot_bcd.mode != bmsd_pkg::BMSD_EPROM |=> boot_select_bcd_oe_n_out)
		else $error("shared select pin driven outside eprom mode");

	a_master_only: assert property (!boot_select_bcd_oe_n_out
		|-> $past(|bus_master_in[3:1]))
		else $error("shared chip select driven by a non-master");

	a_suspend_float: assert property (q.suspended
		|=> boot_select_a_oe_n_out && boot_select_bcd_oe_n_out)
		else $error("chip select driven while bus suspended");

	a_bcd_shared: assert property (boot_mode_out[1] == boot_mode_out[2] &&
		boot_mode_out[2] == boot_mode_out[3])
		else $error("processors b c d disagree on boot mode");

	a_mode_hold: assert property ($past(boot_mode_out[0].valid)
		|-> $stable(boot_mode_out[0]) ##1 $stable(boot_mode_out[0]))
		else $error("processor a boot mode changed after latch");

	// both straps high is reserved whatever the select pin shows
	a_rsvd_decode: assert property ($rose(boot_a.valid) &&
		$past(eprom_boot_strap_a_in, 5) &&
		$past(eprom_boot_strap_a_in, 6) &&
		$past(link_boot_strap_a_in, 5) &&
		$past(link_boot_strap_a_in, 6)
		|-> boot_a.mode == bmsd_pkg::BMSD_RSVD)
		else $error("reserved straps did not give reserved mode");

	// shared group with link strap and select high boots from a link
	a_link_decode: assert property ($rose(boot_bcd.valid) &&
		!$past(eprom_boot_strap_bcd_in, 5) &&
		!$past(eprom_boot_strap_bcd_in, 6) &&
		$past(link_boot_strap_bcd_in, 5) &&
		$past(link_boot_strap_bcd_in, 6) &&
		$past(boot_select_bcd_in, 5) &&
		$past(boot_select_bcd_in, 6)
		|-> boot_bcd.mode == bmsd_pkg::BMSD_LINK)
		else $error("link straps did not give link mode");

	// all three shared straps low means no boot at all
	a_no_boot_decode: assert property ($rose(boot_bcd.valid) &&
		!$past(eprom_boot_strap_bcd_in, 5) &&
		!$past(eprom_boot_strap_bcd_in, 6) &&
		!$past(link_boot_strap_bcd_in, 5) &&
		!$past(link_boot_strap_bcd_in, 6) &&
		!$past(boot_select_bcd_in, 5) &&
		!$past(boot_select_bcd_in, 6)
		|-> boot_bcd.mode == bmsd_pkg::BMSD_NO_BOOT)
		else $error("low straps did not give no-boot mode");

	// run-from-memory flag of b matches its latched no-boot mode
	a_bcd_ext_exec: assert property (ext_exec_out[1] ==
		(boot_mode_out[1].valid &&
		boot_mode_out[1].mode == bmsd_pkg::BMSD_NO_BOOT))
		else $error("external execution flag of b disagrees with mode");

	// a bus slave never drives either chip select
	a_slave_float: assert property (!bus_master_in[0]
		|=> boot_select_a_oe_n_out)
		else $error("select pin a driven by a bus slave");

	a_bcd_slave_float: assert property (bus_master_in[3:1] == 3'h0
		|=> boot_select_bcd_oe_n_out)
		else $error("shared select pin driven by bus slaves");

	// a pin that is not driven shows the idle chip select level
	a_cs_idle: assert property (boot_select_a_oe_n_out
		|-> boot_select_a_out)
		else $error("idle select pin a shows an active chip select");

	a_master_a: assert property (!boot_select_a_oe_n_out
		|-> $past(bus_master_in[0]))
		else $error("select pin a driven by a non-master");

	c_eprom_boot: cover property (!boot_select_a_oe_n_out ##1
		!boot_select_a_out);
	c_link_boot: cover property ($rose(boot_bcd.valid) &&
		boot_bcd.mode == bmsd_pkg::BMSD_LINK);
	c_no_boot: cover property ($rose(ext_exec_out[0]));
	c_host_boot: cover property ($rose(boot_a.valid) &&
		boot_a.mode == bmsd_pkg::BMSD_HOST);
	c_suspend: cover property (!boot_select_a_oe_n_out ##1 q.suspended);
endmodule

// ---- sim/bmsd_board_model.sv ----
// board model: fixed strap ties and the two boot select wires
`timescale 1ns/1ps
module bmsd_board_model (
	// strap levels chosen for the board, {eprom, link, select}
	input wire logic [2:0] cfg_a_in,
	input wire logic [2:0] cfg_bcd_in,
	// boot select pin drivers of the device
	input wire logic sel_a_in,
	input wire logic sel_a_oe_n_in,
	input wire logic sel_bcd_in,
	input wire logic sel_bcd_oe_n_in,
	// strap pins as the device sees them
	output bmsd_pkg::bmsd_strap_t strap_a_out,
	output bmsd_pkg::bmsd_strap_t strap_bcd_out
);
	// straps tied, wire resolved
	// the select wire shows the device's value only while it drives
	always_comb begin
		strap_a_out = bmsd_pkg::bmsd_strap_t'(cfg_a_in);
		strap_bcd_out = bmsd_pkg::bmsd_strap_t'(cfg_bcd_in);
		strap_a_out.sel = sel_a_oe_n_in ? cfg_a_in[0] : sel_a_in;
		strap_bcd_out.sel = sel_bcd_oe_n_in ? cfg_bcd_in[0] : sel_bcd_in;
	end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the boot-mode strap decoder
`timescale 1ns/1ps
module tb_top;
	logic clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic [2:0] cfg_a = 3'h0;
	logic [2:0] cfg_bcd = 3'h0;
	logic susp_n = 1'h1;
	logic [3:0] master = 4'h0;
	logic [3:0] req_n = 4'hf;
	bmsd_pkg::bmsd_strap_t sa;
	bmsd_pkg::bmsd_strap_t sb;
	logic sel_a;
	logic sel_a_oe_n;
	logic sel_bcd;
	logic sel_bcd_oe_n;
	bmsd_pkg::bmsd_boot_t [3:0] mode;
	logic [3:0] ext;
	int n_fail = 0;
	int checks_done = 0;
	// strap sets {eprom, link, select} and the mode each gives
	// the last set is eprom with the select tie low
	logic [2:0] cfg_t [7] = '{3'h5, 3'h1, 3'h3, 3'h0, 3'h2, 3'h6, 3'h4};
	logic [4:0] exp_t [7] = '{5'h08, 5'h02, 5'h04, 5'h01, 5'h10, 5'h10, 5'h08};

	// free-running clock
	always #5 clk_in = ~clk_in;

	bmsd_top dut (
		.clk_in(clk_in), .nrst_in(nrst_in),
		.eprom_boot_strap_a_in(sa.eprom), .link_boot_strap_a_in(sa.link),
		.boot_select_a_in(sa.sel),
		.eprom_boot_strap_bcd_in(sb.eprom), .link_boot_strap_bcd_in(sb.link),
		.boot_select_bcd_in(sb.sel),
		.bus_suspend_n_in(susp_n), .bus_master_in(master),
		.eprom_cs_req_n_in(req_n),
		.boot_select_a_out(sel_a), .boot_select_a_oe_n_out(sel_a_oe_n),
		.boot_select_bcd_out(sel_bcd), .boot_select_bcd_oe_n_out(sel_bcd_oe_n),
		.boot_mode_out(mode), .ext_exec_out(ext)
	);

	bmsd_board_model board (
		.cfg_a_in(cfg_a), .cfg_bcd_in(cfg_bcd),
		.sel_a_in(sel_a), .sel_a_oe_n_in(sel_a_oe_n),
		.sel_bcd_in(sel_bcd), .sel_bcd_oe_n_in(sel_bcd_oe_n),
		.strap_a_out(sa), .strap_bcd_out(sb)
	);

	// compare and count
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// reset at start
	// straps settle before release; latch needs seven edges
	task boot(input int a, input int b);
		nrst_in = 1'h0;
		cfg_a = cfg_t[a];
		cfg_bcd = cfg_t[b];
		cyc(5);
		nrst_in = 1'h1;
		cyc(9);
	endtask

	// a hang counts as a failure
	initial begin
		#20000;
		n_fail++;
		end_sim();
	end

	initial begin
		// every strap set on both groups, all cores master and requesting
		for (int i = 0; i < 7; i++) begin
			int b;
			b = (i + 1) % 7;
			master = 4'hf;
			req_n = 4'h0;
			boot(i, b);
			check({2'h0, mode[0]}, {2'h0, exp_t[i], 1'h1});
			for (int k = 1; k < 4; k++)
				check({2'h0, mode[k]}, {2'h0, exp_t[b], 1'h1});
			check({4'h0, ext}, {4'h0, {3{exp_t[b] == 5'h01}},
				exp_t[i] == 5'h01});
			check({6'h0, sel_a_oe_n, sel_a},
				(exp_t[i] == 5'h08) ? 8'h0 : 8'h3);
			check({6'h0, sel_bcd_oe_n, sel_bcd},
				(exp_t[b] == 5'h08) ? 8'h0 : 8'h3);
		end
		// both groups in eprom mode; strap change after latch is ignored
		boot(0, 0);
		cfg_a = 3'h0;
		cyc(12);
		check({2'h0, mode[0]}, 8'h11);
		// only processor a masters the bus
		master = 4'h1;
		cyc(2);
		check({6'h0, sel_bcd_oe_n, sel_bcd}, 8'h3);
		check({6'h0, sel_a_oe_n, sel_a}, 8'h0);
		req_n = 4'hf;
		cyc(2);
		check({6'h0, sel_a_oe_n, sel_a}, 8'h1);
		susp_n = 1'h0;
		cyc(6);
		check({6'h0, sel_a_oe_n, sel_a}, 8'h3);
		susp_n = 1'h1;
		cyc(6);
		check({6'h0, sel_a_oe_n, sel_a}, 8'h1);
		// c alone masters the bus: shared pin follows its request only
		master = 4'h4;
		req_n = 4'hb;
		cyc(2);
		check({6'h0, sel_bcd_oe_n, sel_bcd}, 8'h0);
		check({6'h0, sel_a_oe_n, sel_a}, 8'h3);
		req_n = 4'h4;
		cyc(2);
		check({6'h0, sel_bcd_oe_n, sel_bcd}, 8'h1);
		end_sim();
	end
endmodule
